// ===== rtl/uep_pkg.sv
// constants for the endpoint event, enable and data port block
package uep_pkg;
  // endpoint and bank geometry
  localparam int NUM_EP = 5;
  localparam int BANK_BYTES = 64;
  localparam int EP_W = 3;
  localparam int PTR_W = 6;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hF0;
  localparam logic [7:0] IDX_BYTE_COUNT = 8'hF2;
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'hE0;
  localparam logic [7:0] IDX_DATA_PORT = 8'hE1;
  localparam logic [7:0] IDX_SUMMARY = 8'hE2;
  localparam logic [7:0] IDX_EP_SELECT = 8'hE3;
  localparam logic [7:0] IDX_EP_DIRECTION = 8'hE4;
  localparam logic [7:0] IDX_FLOW_STATUS = 8'hE5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = {2'h0, IDX_IRQ_ENABLE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_BYTE_COUNT = {2'h0, IDX_BYTE_COUNT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS = {2'h0, IDX_EVENT_FLAGS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DATA_PORT = {2'h0, IDX_DATA_PORT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SUMMARY = {2'h0, IDX_SUMMARY, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EP_SELECT = {2'h0, IDX_EP_SELECT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EP_DIRECTION = {2'h0, IDX_EP_DIRECTION, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FLOW_STATUS = {2'h0, IDX_FLOW_STATUS, 2'h0};
  // event flag bit positions
  localparam int FLAG_BANK_CONTROL = 7;
  localparam int FLAG_NAK_IN = 6;
  localparam int FLAG_RW_ALLOWED = 5;
  localparam int FLAG_NAK_OUT = 4;
  localparam int FLAG_SETUP = 3;
  localparam int FLAG_OUT_RX = 2;
  localparam int FLAG_STALL = 1;
  localparam int FLAG_TX_READY = 0;
  // enable bit positions and the always-zero hole
  localparam int EN_FLOW_ERROR = 7;
  localparam logic [7:0] EN_WRITABLE_MASK = 8'hDF;
  // flow status bit positions
  localparam int FLOW_OVERFLOW = 6;
  localparam int FLOW_UNDERFLOW = 5;
  // values after reset
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_BYTE_COUNT = 8'h00;
  localparam logic [EP_W-1:0] RST_EP_SELECT = 3'h0;
  localparam logic [NUM_EP-1:0] RST_DIRECTION = 5'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/uep_top.sv
// endpoint event flags, interrupt enables, data port, byte count and summary
// What this block does
// - OUT endpoint sets received-OUT flag when its bank gets a new packet.
// - on IN endpoint, writing one to bit 2 kills loaded bank; zero ignored.
// - stall flag set after STALL sent or isochronous OUT CRC error.
// - transmitter-ready flag set when bank is freed: transmit done, kill, or turning the endpoint IN.
// - writing zero clears received-OUT, stall, tx-ready flags; one leaves them.
// - flow-error enable lets overflow or underflow flag raise the interrupt.
// - NAK-IN enable lets the NAK-IN flag raise the interrupt.
// - NAK-OUT enable lets the NAK-OUT flag raise the interrupt.
// - setup enable lets the setup-received flag raise the interrupt.
// - received-OUT enable lets the received-OUT flag raise the interrupt.
// - stall enable lets the stall flag raise the interrupt.
// - tx-ready enable lets the tx-ready flag raise the interrupt.
// - interrupt needs flag set, its enable one, and global enable set.
// - enable register bit 5 always reads zero.
// - data port write pushes a byte; read pops a byte from current bank.
// - byte count is read-only; only the controller changes it.
// - IN endpoint byte count is bytes loaded, plus one per push.
// - OUT endpoint byte count is bytes left, minus one per pop.
// - summary bit per endpoint set while any flag set, clears by itself.
// - summary bits 7:5 read zero; firmware never writes ones there.
// - OUT endpoint: writing zero to bank control releases bank, goes next.
`timescale 1ns/1ps
`default_nettype none
module uep_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [uep_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [uep_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // processor global interrupt enable and request
  input wire logic cpu_status_global_irq,
  output logic endpoint_irq,
  // usb engine side, endpoint addressed by usb_ep
  input wire logic [uep_pkg::EP_W-1:0] usb_ep,
  input wire logic usb_rx_we,
  input wire logic [7:0] usb_rx_data,
  input wire logic usb_rx_end,
  input wire logic usb_setup_rx,
  input wire logic usb_tx_re,
  output logic [7:0] usb_tx_data,
  input wire logic usb_tx_sent,
  input wire logic usb_stall_sent,
  input wire logic usb_iso_crc_err,
  input wire logic usb_nak_in,
  input wire logic usb_nak_out,
  input wire logic usb_iso_overflow,
  input wire logic usb_iso_underflow,
  output logic [uep_pkg::NUM_EP-1:0] usb_bank_busy
);
  import uep_pkg::*;

  // per-endpoint state
  logic [7:0] irq_enable [NUM_EP];
  logic [7:0] byte_count [NUM_EP];
  logic [PTR_W-1:0] bank_ptr [NUM_EP];
  logic [NUM_EP-1:0] bank_control, bank_busy, dir_in, endpoint_pending_bits, ep_irq_hit;
  logic [NUM_EP-1:0] nak_in_flag, nak_out_flag, setup_received_flag, out_received_flag;
  logic [NUM_EP-1:0] stall_sent_flag, tx_ready_flag, iso_overflow_flag, iso_underflow_flag;
  logic [EP_W-1:0] ep_select;
  logic [7:0] bank_mem [0:NUM_EP*BANK_BYTES-1];

  // bus slave state and decoded actions
  logic aw_held, w_held, w_lane0_q, wr_fire, rd_fire, wr_mapped, rd_mapped;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q, rd_byte, sel_flags;
  logic sel_ok, usb_ok, sel_rw_allowed;
  logic [EP_W-1:0] sel, uep;
  logic wr_flags, wr_enable, wr_data, wr_select, wr_direction, wr_flow;
  logic fw_push, fw_pop, fw_send, fw_kill, fw_release;
  logic usb_rx_ok, usb_pkt_done, usb_tx_ok, usb_in_done;

  // endpoint indices clipped so arrays are never read out of range
  assign sel_ok = (ep_select < EP_W'(NUM_EP));
  assign usb_ok = (usb_ep < EP_W'(NUM_EP));
  assign sel = sel_ok ? ep_select : '0;
  assign uep = usb_ok ? usb_ep : '0;

  // a write is carried out once address and data are both held
  assign awready = !aw_held;
  assign wready = !w_held;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;

  // write decode; byte lane 0 carries every register
  always_comb begin
    wr_flags = 1'b0;
    wr_enable = 1'b0;
    wr_data = 1'b0;
    wr_select = 1'b0;
    wr_direction = 1'b0;
    wr_flow = 1'b0;
    wr_mapped = 1'b1;
    unique case (aw_addr_q)
      ADDR_EVENT_FLAGS: wr_flags = wr_fire && w_lane0_q && sel_ok;
      ADDR_IRQ_ENABLE: wr_enable = wr_fire && w_lane0_q && sel_ok;
      ADDR_DATA_PORT: wr_data = wr_fire && w_lane0_q && sel_ok;
      ADDR_EP_SELECT: wr_select = wr_fire && w_lane0_q;
      ADDR_EP_DIRECTION: wr_direction = wr_fire && w_lane0_q;
      ADDR_FLOW_STATUS: wr_flow = wr_fire && w_lane0_q && sel_ok;
      ADDR_BYTE_COUNT, ADDR_SUMMARY: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // bank actions from firmware
  assign fw_push = wr_data && dir_in[sel] && !bank_busy[sel] && (byte_count[sel] < 8'(BANK_BYTES));
  assign fw_pop = rd_fire && (araddr == ADDR_DATA_PORT) && sel_ok && !dir_in[sel] && bank_busy[sel]
                  && (byte_count[sel] != 8'h00);
  assign fw_send = wr_flags && !w_byte_q[FLAG_BANK_CONTROL] && dir_in[sel] && !bank_busy[sel];
  assign fw_kill = wr_flags && w_byte_q[FLAG_OUT_RX] && dir_in[sel] && bank_busy[sel];
  assign fw_release = wr_flags && !w_byte_q[FLAG_BANK_CONTROL] && !dir_in[sel] && bank_busy[sel];

  // bank actions from the usb engine
  assign usb_rx_ok = usb_rx_we && usb_ok && !dir_in[uep] && !bank_busy[uep]
                     && (byte_count[uep] < 8'(BANK_BYTES));
  assign usb_pkt_done = (usb_rx_end || usb_setup_rx) && usb_ok && !dir_in[uep] && !bank_busy[uep];
  assign usb_tx_ok = usb_tx_re && usb_ok && dir_in[uep] && bank_busy[uep];
  assign usb_in_done = usb_tx_sent && usb_ok && dir_in[uep] && bank_busy[uep];

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // selected endpoint view of the event flags
  assign sel_rw_allowed = dir_in[sel] ? (!bank_busy[sel] && (byte_count[sel] < 8'(BANK_BYTES)))
                                      : (bank_busy[sel] && (byte_count[sel] != 8'h00));
  always_comb begin
    sel_flags = 8'h00;
    sel_flags[FLAG_BANK_CONTROL] = bank_control[sel];
    sel_flags[FLAG_NAK_IN] = nak_in_flag[sel];
    sel_flags[FLAG_RW_ALLOWED] = sel_rw_allowed && !stall_sent_flag[sel];
    sel_flags[FLAG_NAK_OUT] = nak_out_flag[sel];
    sel_flags[FLAG_SETUP] = setup_received_flag[sel];
    sel_flags[FLAG_OUT_RX] = out_received_flag[sel];
    sel_flags[FLAG_STALL] = stall_sent_flag[sel];
    sel_flags[FLAG_TX_READY] = tx_ready_flag[sel];
  end

  // read mux; per-endpoint registers read zero for an invalid selection
  always_comb begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    unique case (araddr)
      ADDR_IRQ_ENABLE: rd_byte = sel_ok ? (irq_enable[sel] & EN_WRITABLE_MASK) : 8'h00;
      ADDR_BYTE_COUNT: rd_byte = sel_ok ? byte_count[sel] : 8'h00;
      ADDR_EVENT_FLAGS: rd_byte = sel_ok ? sel_flags : 8'h00;
      ADDR_DATA_PORT: rd_byte = fw_pop ? bank_mem[{sel, bank_ptr[sel]}] : 8'h00;
      ADDR_SUMMARY: rd_byte = {3'h0, endpoint_pending_bits};
      ADDR_EP_SELECT: rd_byte = {5'h00, ep_select};
      ADDR_EP_DIRECTION: rd_byte = {3'h0, dir_in};
      ADDR_FLOW_STATUS: rd_byte = sel_ok ? {1'b0, iso_overflow_flag[sel], iso_underflow_flag[sel], 5'h00} : 8'h00;
      default: rd_mapped = 1'b0;
    endcase
  end

  // read channel; the pop happens at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // endpoint selection and direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep_select <= RST_EP_SELECT;
      dir_in <= RST_DIRECTION;
    end else begin
      if (wr_select) begin
        ep_select <= w_byte_q[EP_W-1:0];
      end
      if (wr_direction) begin
        dir_in <= w_byte_q[NUM_EP-1:0];
      end
    end
  end

  // interrupt enables; bit 5 is never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int e = 0; e < NUM_EP; e++) begin
        irq_enable[e] <= RST_IRQ_ENABLE;
      end
    end else if (wr_enable) begin
      irq_enable[sel] <= w_byte_q & EN_WRITABLE_MASK;
    end
  end

  // event flags: hardware set wins over a same-cycle software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nak_in_flag <= '0;
      nak_out_flag <= '0;
      setup_received_flag <= '0;
      out_received_flag <= '0;
      stall_sent_flag <= '0;
      tx_ready_flag <= '0;
      iso_overflow_flag <= '0;
      iso_underflow_flag <= '0;
    end else begin
      for (int e = 0; e < NUM_EP; e++) begin
        logic fl_here;
        logic fw_here;
        logic us_here;
        fl_here = wr_flags && (sel == EP_W'(e));
        fw_here = wr_flow && (sel == EP_W'(e));
        us_here = usb_ok && (usb_ep == EP_W'(e));
        nak_in_flag[e] <= (nak_in_flag[e] && !(fl_here && !w_byte_q[FLAG_NAK_IN])) || (us_here && usb_nak_in);
        nak_out_flag[e] <= (nak_out_flag[e] && !(fl_here && !w_byte_q[FLAG_NAK_OUT]))
                           || (us_here && usb_nak_out);
        setup_received_flag[e] <= (setup_received_flag[e] && !(fl_here && !w_byte_q[FLAG_SETUP]))
                                  || (us_here && usb_pkt_done && usb_setup_rx);
        // on an IN endpoint bit 2 is the kill control, so it never clears here
        out_received_flag[e] <= (out_received_flag[e] && !(fl_here && !dir_in[e] && !w_byte_q[FLAG_OUT_RX]))
                                || (us_here && usb_pkt_done && !usb_setup_rx);
        stall_sent_flag[e] <= (stall_sent_flag[e] && !(fl_here && !w_byte_q[FLAG_STALL]))
                              || (us_here && (usb_stall_sent || (usb_iso_crc_err && !dir_in[e])));
        // bank freed by transmission, by a kill, or on turning the endpoint IN
        tx_ready_flag[e] <= (tx_ready_flag[e] && !(fl_here && !w_byte_q[FLAG_TX_READY]))
                            || (us_here && usb_in_done) || (fl_here && fw_kill)
                            || (wr_direction && w_byte_q[e] && !dir_in[e]);
        iso_overflow_flag[e] <= (iso_overflow_flag[e] && !(fw_here && !w_byte_q[FLOW_OVERFLOW]))
                                || (us_here && usb_iso_overflow);
        iso_underflow_flag[e] <= (iso_underflow_flag[e] && !(fw_here && !w_byte_q[FLOW_UNDERFLOW]))
                                 || (us_here && usb_iso_underflow);
      end
    end
  end

  // bank ownership, byte count and pointer per endpoint
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_busy <= '0;
      bank_control <= '0;
      for (int e = 0; e < NUM_EP; e++) begin
        byte_count[e] <= RST_BYTE_COUNT;
        bank_ptr[e] <= '0;
      end
    end else begin
      for (int e = 0; e < NUM_EP; e++) begin
        logic s_here;
        logic u_here;
        s_here = (sel == EP_W'(e));
        u_here = usb_ok && (usb_ep == EP_W'(e));
        if (s_here && fw_push) begin
          byte_count[e] <= byte_count[e] + 8'h01;
        end
        if (s_here && fw_pop) begin
          byte_count[e] <= byte_count[e] - 8'h01;
          bank_ptr[e] <= bank_ptr[e] + PTR_W'(1);
        end
        if (s_here && fw_send) begin
          bank_busy[e] <= 1'b1;
          bank_control[e] <= 1'b0;
          bank_ptr[e] <= '0;
        end
        // kill and transmit-done both hand an empty bank back to firmware
        if ((s_here && fw_kill) || (u_here && usb_in_done)) begin
          bank_busy[e] <= 1'b0;
          bank_control[e] <= 1'b1;
          byte_count[e] <= 8'h00;
          bank_ptr[e] <= '0;
        end
        if (u_here && usb_tx_ok) begin
          bank_ptr[e] <= bank_ptr[e] + PTR_W'(1);
        end
        if (u_here && usb_rx_ok) begin
          byte_count[e] <= byte_count[e] + 8'h01;
        end
        if (u_here && usb_pkt_done) begin
          bank_busy[e] <= 1'b1;
          bank_control[e] <= 1'b1;
          bank_ptr[e] <= '0;
        end
        if (s_here && fw_release) begin
          bank_busy[e] <= 1'b0;
          bank_control[e] <= 1'b0;
          byte_count[e] <= 8'h00;
          bank_ptr[e] <= '0;
        end
      end
    end
  end

  // bank storage; firmware fills IN banks, the engine fills OUT banks
  always_ff @(posedge aclk) begin
    if (fw_push) begin
      bank_mem[{sel, byte_count[sel][PTR_W-1:0]}] <= w_byte_q;
    end
    if (usb_rx_ok) begin
      bank_mem[{uep, byte_count[uep][PTR_W-1:0]}] <= usb_rx_data;
    end
  end

  // transmit byte for the engine, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_tx_data <= 8'h00;
    end else if (usb_tx_ok) begin
      usb_tx_data <= bank_mem[{uep, bank_ptr[uep]}];
    end
  end

  // per-endpoint pending summary and enabled-source hit
  always_comb begin
    for (int e = 0; e < NUM_EP; e++) begin
      endpoint_pending_bits[e] = nak_in_flag[e] || nak_out_flag[e] || setup_received_flag[e]
                                 || out_received_flag[e] || stall_sent_flag[e] || tx_ready_flag[e]
                                 || iso_overflow_flag[e] || iso_underflow_flag[e];
      ep_irq_hit[e] = (irq_enable[e][EN_FLOW_ERROR] && (iso_overflow_flag[e] || iso_underflow_flag[e]))
                      || (irq_enable[e][FLAG_NAK_IN] && nak_in_flag[e])
                      || (irq_enable[e][FLAG_NAK_OUT] && nak_out_flag[e])
                      || (irq_enable[e][FLAG_SETUP] && setup_received_flag[e])
                      || (irq_enable[e][FLAG_OUT_RX] && out_received_flag[e])
                      || (irq_enable[e][FLAG_STALL] && stall_sent_flag[e])
                      || (irq_enable[e][FLAG_TX_READY] && tx_ready_flag[e]);
    end
  end

  // single request, registered so it never glitches toward the processor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      endpoint_irq <= 1'b0;
    end else begin
      endpoint_irq <= cpu_status_global_irq && (|ep_irq_hit);
    end
  end

  assign usb_bank_busy = bank_busy;

endmodule
`default_nettype wire

// ===== bench/uep_props.sv
// port assertions for the endpoint block
`timescale 1ns/1ps
`default_nettype none
module uep_props (
  // clock, reset and register bus
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uep_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic bvalid,
  input wire logic bready,
  // interrupt and engine side
  input wire logic cpu_status_global_irq,
  input wire logic endpoint_irq,
  input wire logic usb_rx_end,
  input wire logic usb_setup_rx,
  input wire logic [uep_pkg::NUM_EP-1:0] usb_bank_busy
);
  import uep_pkg::*;
  logic [ADDR_W-1:0] rd_a;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address of the read in flight, so its answer can be judged
  always_ff @(posedge aclk) begin
    if (arvalid && !rvalid) begin
      rd_a <= araddr;
    end
  end
  AST_RLAT: assert property (arvalid && !rvalid |=> rvalid)
    else $error("read answer late");
  AST_RTOP: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data above the byte");
  AST_HOLE: assert property (rvalid && rd_a == ADDR_IRQ_ENABLE |-> !rdata[5])
    else $error("enable hole reads one");
  AST_SUMT: assert property (rvalid && rd_a == ADDR_SUMMARY |-> rdata[7:5] == 3'h0)
    else $error("summary top bits set");
  AST_RERR: assert property (rvalid && rresp != RESP_OKAY |-> rdata == 32'h0)
    else $error("refused read carries data");
  AST_GATE: assert property (!cpu_status_global_irq |=> !endpoint_irq)
    else $error("interrupt with global enable off");
  AST_BCLR: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  AST_BUSY: assert property ($rose(usb_bank_busy[0]) |-> $past(usb_rx_end || usb_setup_rx) || $rose(bvalid))
    else $error("bank busy without cause");
endmodule
`default_nettype wire

// ===== bench/uep_usb_model.sv
// behavioural usb engine driving the endpoint block strobes
`timescale 1ns/1ps
`default_nettype none
module uep_usb_model (
  // clock
  input wire logic aclk,
  // endpoint number, strobes and received byte
  output logic [uep_pkg::EP_W-1:0] usb_ep,
  output logic usb_rx_we,
  output logic [7:0] usb_rx_data,
  output logic usb_rx_end,
  output logic usb_setup_rx,
  output logic usb_tx_re,
  output logic usb_tx_sent,
  output logic usb_stall_sent,
  output logic usb_iso_crc_err,
  output logic usb_nak_in,
  output logic usb_nak_out,
  output logic usb_iso_overflow,
  output logic usb_iso_underflow
);
  import uep_pkg::*;
  logic [10:0] st = 11'h0;
  logic [7:0] byte_q = 8'h00;
  // one strobe at a time, each one cycle long
  assign {usb_iso_underflow, usb_iso_overflow, usb_nak_out, usb_nak_in, usb_iso_crc_err, usb_stall_sent,
    usb_tx_sent, usb_tx_re, usb_setup_rx, usb_rx_end, usb_rx_we} = st;
  // inverse byte between stores so a stale value never passes
  assign usb_rx_data = usb_rx_we ? byte_q : ~byte_q;
  initial usb_ep = 3'h0;
  task automatic pulse(input int k, input logic [EP_W-1:0] ep);
    @(posedge aclk);
    usb_ep <= ep;
    st <= 11'h1 << k;
    @(posedge aclk);
    st <= 11'h0;
  endtask
  // packet of n bytes counting up from A0, then the end strobe
  task automatic rx(input logic [EP_W-1:0] ep, input int n);
    for (int i = 0; i < n; i++) begin
      byte_q <= 8'hA0 + 8'(i);
      pulse(0, ep);
    end
    pulse(1, ep);
  endtask
endmodule
`default_nettype wire

// ===== bench/uep_tb.sv
// self-checking bench for the endpoint block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uep_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid, endpoint_irq;
  logic cpu_status_global_irq, usb_rx_we, usb_rx_end, usb_setup_rx, usb_tx_re, usb_tx_sent, usb_stall_sent;
  logic usb_iso_crc_err, usb_nak_in, usb_nak_out, usb_iso_overflow, usb_iso_underflow;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, rs;
  logic [EP_W-1:0] usb_ep;
  logic [7:0] usb_rx_data, usb_tx_data, v;
  logic [NUM_EP-1:0] usb_bank_busy;
  int miscompares, cmp_count;
  // per event kind: engine strobe, enable bit, flag bit
  int kind [7] = '{7, 8, 2, 5, 6, 9, 10};
  int enb [7] = '{6, 4, 3, 1, 1, 7, 7};
  int fbit [7] = '{6, 4, 3, 1, 1, 6, 5};
  uep_top dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
    .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready(1'b1), .cpu_status_global_irq, .endpoint_irq, .usb_ep, .usb_rx_we, .usb_rx_data,
    .usb_rx_end, .usb_setup_rx, .usb_tx_re, .usb_tx_data, .usb_tx_sent, .usb_stall_sent, .usb_iso_crc_err,
    .usb_nak_in, .usb_nak_out, .usb_iso_overflow, .usb_iso_underflow, .usb_bank_busy);
  uep_usb_model host (.aclk, .usb_ep, .usb_rx_we, .usb_rx_data, .usb_rx_end, .usb_setup_rx, .usb_tx_re,
    .usb_tx_sent, .usb_stall_sent, .usb_iso_crc_err, .usb_nak_in, .usb_nak_out, .usb_iso_overflow,
    .usb_iso_underflow);
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // hang guard, well past the few hundred cycles the tests need
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // axi write; each valid drops at its own handshake edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata[7:0];
    rs = rresp;
  endtask
  task automatic rc(input string n, input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(n, v & m, e);
  endtask
  // request follows its causes by one cycle; two gives margin
  task automatic ci(input string n, input logic e);
    repeat (2) @(posedge aclk);
    chk(n, {7'h0, endpoint_irq}, {7'h0, e});
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, cpu_status_global_irq} = 4'h0;
    {awaddr, araddr, wdata} = 56'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ien", ADDR_IRQ_ENABLE, 8'hFF, RST_IRQ_ENABLE);
    rc("bcnt", ADDR_BYTE_COUNT, 8'hFF, RST_BYTE_COUNT);
    wr(ADDR_IRQ_ENABLE, 8'hFF);
    rc("ien hole", ADDR_IRQ_ENABLE, 8'hFF, EN_WRITABLE_MASK);
    wr(ADDR_BYTE_COUNT, 8'h55);
    chk("bcnt wr resp", {6'h0, rs}, {6'h0, RESP_OKAY});
    rc("bcnt ro", ADDR_BYTE_COUNT, 8'hFF, 8'h00);
    rd(12'hFFC);
    chk("unmapped", {6'h0, rs}, {6'h0, RESP_SLVERR});
    wr(12'hFFC, 8'h00);
    chk("wr unmapped", {6'h0, rs}, {6'h0, RESP_SLVERR});
    $display("registers done");
    // out packet on endpoint zero; the clock keeps running while flags clear
    wr(ADDR_IRQ_ENABLE, 8'h04);
    cpu_status_global_irq <= 1'b1;
    host.rx(3'h0, 3);
    wr(ADDR_EVENT_FLAGS, 8'hFF);
    rc("rx flag", ADDR_EVENT_FLAGS, 8'h04, 8'h04);
    rc("rx cnt", ADDR_BYTE_COUNT, 8'hFF, 8'h03);
    rc("sum", ADDR_SUMMARY, 8'hFF, 8'h01);
    ci("irq", 1'b1);
    cpu_status_global_irq <= 1'b0;
    ci("gated", 1'b0);
    for (int i = 0; i < 3; i++) rc("pop", ADDR_DATA_PORT, 8'hFF, 8'hA0 + 8'(i));
    rc("rx cnt", ADDR_BYTE_COUNT, 8'hFF, 8'h00);
    wr(ADDR_EVENT_FLAGS, 8'h7B);
    rc("rx clr", ADDR_EVENT_FLAGS, 8'h04, 8'h00);
    chk("release", {7'h0, usb_bank_busy[0]}, 8'h00);
    rc("sum clr", ADDR_SUMMARY, 8'hFF, 8'h00);
    $display("out done");
    // every other event kind but tx-ready, masked first and then enabled
    cpu_status_global_irq <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      host.pulse(kind[i], 3'h0);
      rc("event", i < 5 ? ADDR_EVENT_FLAGS : ADDR_FLOW_STATUS, 8'h01 << fbit[i], 8'h01 << fbit[i]);
      ci("masked", 1'b0);
      wr(ADDR_IRQ_ENABLE, 8'h01 << enb[i]);
      ci("enabled", 1'b1);
      wr(i < 5 ? ADDR_EVENT_FLAGS : ADDR_FLOW_STATUS, 8'h00);
      wr(ADDR_IRQ_ENABLE, 8'h00);
    end
    $display("events done");
    // in endpoint one: fill, send, kill, refill and transmit
    wr(ADDR_EP_SELECT, 8'h01);
    wr(ADDR_EP_DIRECTION, 8'h02);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    ci("tx irq", 1'b1);
    for (int i = 1; i < 3; i++) begin
      wr(ADDR_DATA_PORT, 8'h5A);
      rc("tx cnt", ADDR_BYTE_COUNT, 8'hFF, 8'(i));
    end
    wr(ADDR_EVENT_FLAGS, 8'h7B);
    chk("sent", {7'h0, usb_bank_busy[1]}, 8'h01);
    wr(ADDR_EVENT_FLAGS, 8'hFF);
    chk("killed", {7'h0, usb_bank_busy[1]}, 8'h00);
    rc("kill cnt", ADDR_BYTE_COUNT, 8'hFF, 8'h00);
    wr(ADDR_DATA_PORT, 8'hC3);
    wr(ADDR_EVENT_FLAGS, 8'h7A);
    rc("tx rdy clr", ADDR_EVENT_FLAGS, 8'h01, 8'h00);
    host.pulse(3, 3'h1);
    // transmit byte is registered, so look one edge after the strobe is taken
    @(posedge aclk);
    chk("tx byte", usb_tx_data, 8'hC3);
    host.pulse(4, 3'h1);
    rc("tx rdy", ADDR_EVENT_FLAGS, 8'h01, 8'h01);
    $display("in done");
    summarize();
  end
endmodule
bind uep_top uep_props props (.aclk, .aresetn, .araddr, .arvalid, .rdata, .rresp, .rvalid, .bvalid, .bready,
  .cpu_status_global_irq, .endpoint_irq, .usb_rx_end, .usb_setup_rx, .usb_bank_busy);
`default_nettype wire
